// ### dv/abx_exec_chk.sv
// abx_exec_chk: port-level assertions for the executor, bound to abx_exec.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ns
module abx_exec_chk
    import abx_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               srst,
    input wire logic               instrValid,
    input wire logic [INSTR_W-1:0] instrWord,
    input wire logic               discardNext,
    input wire logic               instrRetired,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_word_retired: assert property (instrValid |=> instrRetired)
        else $error("valid word not retired");
    a_skip_hold: assert property (discardNext && !instrValid |=> discardNext)
        else $error("pending skip lost without a word");
    a_skip_consume: assert property (discardNext && instrValid |=> !discardNext)
        else $error("pending skip not consumed");
    a_skip_source: assert property (instrValid && instrWord[11:8] != OPC_BIT_TEST
        |=> !discardNext)
        else $error("skip raised by a non-test word");
    a_reset_clear: assert property (disable iff (1'b0)
        srst |=> !wb_ack_o && !discardNext && !instrRetired)
        else $error("outputs not cleared by reset");
endmodule

bind abx_exec abx_exec_chk u_chk (.core_clk, .srst, .instrValid, .instrWord, .discardNext,
    .instrRetired, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ### dv/abx_fetch_model.sv
// abx_fetch_model: fetch unit stand-in that presents one word per request.
// assumes the bench raises wantValid for one cycle per word.
`timescale 1ns/1ns
module abx_fetch_model
    import abx_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               wantValid,
    input  wire logic [INSTR_W-1:0] wantWord,
    output logic                    instrValid,
    output logic [INSTR_W-1:0]      instrWord
);
    // idle word toggles so a stale opcode is never mistaken for a held one
    always_ff @(posedge core_clk) begin
        instrValid <= wantValid && !srst;
        instrWord  <= srst ? 12'h000 : (wantValid ? wantWord : ~instrWord);
    end
endmodule

// ### dv/tb_top.sv
// tb_top: random instruction stream against a reference model, read back over the bus.
// assumes abx_exec with the register map of abx_pkg and a 100 ns clock.
`timescale 1ns/1ns
module tb_top;
    import abx_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        wantValid = 1'b0;
    logic [11:0] wantWord = 12'h000;
    logic        instrValid;
    logic [11:0] instrWord;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wbAck;
    logic        discard;
    logic        retired;
    logic [3:0]  sel = 4'h1;
    int          nRetired = 0;
    logic [31:0] expQ[$];
    logic [31:0] e;
    int          n_fail = 0;
    int          checked = 0;
    int          nWords = 0;

    always #50 core_clk = ~core_clk;

    abx_fetch_model u_fetch (.core_clk(core_clk), .srst(srst), .wantValid(wantValid),
        .wantWord(wantWord), .instrValid(instrValid), .instrWord(instrWord));
    abx_exec DUT (.core_clk(core_clk), .srst(srst), .instrValid(instrValid),
        .instrWord(instrWord), .discardNext(discard), .instrRetired(retired), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(wbAck));

    task automatic complete_run();
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        if (!wr) expQ.push_back(d);
        cyc <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic ex(input logic [11:0] wd);
        wantValid <= 1'b1;
        wantWord <= wd;
        nWords++;
        @(posedge core_clk);
        wantValid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (retired === 1'b1) nRetired++;
        if (wbAck === 1'b1 && !we) begin
            e = expQ.pop_front();
            checked++;
            if (rdat !== e) begin
                n_fail++;
                $display("unexpected read at %h: expected %h seen %h", adr, e, rdat);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end

    initial begin
        logic [2:0]  op;
        logic [4:0]  f;
        logic [2:0]  b;
        logic [7:0]  k;
        logic [7:0]  fv;
        logic [7:0]  w;
        logic [11:0] wd;
        logic        d;
        logic        z;
        logic        sk;
        void'($urandom(32'h95da7a79));
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, ADDR_WREG, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        bus(1'b0, 8'hfc, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        sel <= 4'h0;
        bus(1'b1, ADDR_WREG, 32'h0000_005a);
        sel <= 4'h1;
        bus(1'b0, ADDR_WREG, 32'h0);
        for (int i = 0; i < 60; i++) begin
            op = 3'($urandom_range(4));
            {f, b, k, d, z, fv, w} = 34'({$urandom, $urandom});
            bus(1'b1, ADDR_WREG, {24'h0, w});
            bus(1'b1, ADDR_STATUS, {31'h0, z});
            bus(1'b1, {1'b1, f, 2'b00}, {24'h0, fv});
            sk = 1'b0;
            case (op)
                3'd0: begin
                    wd = {OPC_AND_LIT, k};
                    w = w & k;
                    z = (w == 8'h00);
                end
                3'd1: begin
                    wd = {OPC_AND_REG, d, f};
                    k = w & fv;
                    if (d) fv = k;
                    else w = k;
                    z = (k == 8'h00);
                end
                3'd2: begin
                    wd = {OPC_BIT_CLEAR, b, f};
                    fv[b] = 1'b0;
                end
                3'd3: begin
                    wd = {OPC_BIT_SET, b, f};
                    fv[b] = 1'b1;
                end
                default: begin
                    wd = {OPC_BIT_TEST, b, f};
                    sk = !fv[b];
                end
            endcase
            ex(wd);
            checked++;
            if (discard !== sk) begin
                n_fail++;
                $display("unexpected discardNext: expected %b seen %b", sk, discard);
            end
            if (sk) begin
                bus(1'b0, ADDR_STATUS, {30'h0, 1'b1, z});
                ex({OPC_AND_LIT, 8'h00});
            end
            bus(1'b0, ADDR_WREG, {24'h0, w});
            bus(1'b0, ADDR_STATUS, {31'h0, z});
            bus(1'b0, {1'b1, f, 2'b00}, {24'h0, fv});
        end
        bus(1'b0, ADDR_CYCLES, 32'(nWords));
        checked++;
        if (nRetired != nWords) begin
            n_fail++;
            $display("unexpected instrRetired count: expected %0d seen %0d", nWords, nRetired);
        end
        complete_run();
    end
endmodule

// ### rtl/abx_alu.sv
// abx_alu: AND and single-bit operations on 8-bit data.
// assumes operands are already selected by the executor.
`timescale 1ns/1ns
module abx_alu
    import abx_pkg::*;
(
    input  abx_op_t             op,
    input  wire logic [7:0]     wVal,
    input  wire logic [7:0]     fVal,
    input  wire logic [7:0]     literal,
    input  wire logic [2:0]     bitSel,
    output abx_alu_t            res
);

    function automatic logic [7:0] bitMask(input logic [2:0] sel);
        bitMask = 8'h01 << sel;
    endfunction

    always_comb begin
        res.bitSet = |(fVal & bitMask(bitSel));
        case (op)
            ABX_OP_ANDL: res.value = wVal & literal;               // RQ10
            ABX_OP_ANDF: res.value = wVal & fVal;                  // RQ1
            ABX_OP_BCLR: res.value = fVal & ~bitMask(bitSel);      // RQ5
            ABX_OP_BSET: res.value = fVal | bitMask(bitSel);       // RQ6
            default:     res.value = fVal;
        endcase
        res.zero = (res.value == 8'h00);  // RQ11
    end

endmodule

// ### rtl/abx_decode.sv
// abx_decode: combinational split of a 12-bit word into operation and fields.
// assumes the caller qualifies the result with its own valid signal.
`timescale 1ns/1ns
module abx_decode
    import abx_pkg::*;
(
    input  wire logic [INSTR_W-1:0] instr,
    output abx_dec_t                dec
);

    always_comb begin
        dec.op       = ABX_OP_NONE;
        dec.destFile = instr[D_POS];
        dec.fileAddr = instr[F_MSB:F_LSB];  // RQ7
        dec.bitSel   = instr[B_MSB:B_LSB];  // RQ7
        dec.literal  = instr[K_MSB:K_LSB];
        if (instr[INSTR_W-1 -: $bits(OPC_AND_REG)] == OPC_AND_REG) begin
            dec.op = ABX_OP_ANDF;  // RQ4
        end else begin
            case (instr[INSTR_W-1 -: $bits(OPC_BIT_CLEAR)])
                OPC_BIT_CLEAR: dec.op = ABX_OP_BCLR;  // RQ5
                OPC_BIT_SET:   dec.op = ABX_OP_BSET;  // RQ6
                OPC_BIT_TEST:  dec.op = ABX_OP_BTSC;  // RQ8
                OPC_AND_LIT:   dec.op = ABX_OP_ANDL;  // RQ10
                default:       dec.op = ABX_OP_NONE;
            endcase
        end
    end

endmodule

// ### rtl/abx_exec.sv
// abx_exec: executes AND, bit clear, bit set and bit-test-skip-if-clear
// instructions against a local 32 x 8 file register space, and exposes the
// working register, status and file registers to software over classic Wishbone.
// assumes the fetch unit offers one instruction per cycle with instrValid and
// honours discardNext by letting the flagged word run as a no-operation here.
// Operation
// RQ1 - register-AND forms W AND the addressed file register.
// RQ2 - destination bit 0: result goes to W, file register unchanged.
// RQ3 - destination bit 1: result written back to the addressed file register.
// RQ4 - register-AND is recognised by upper bits 0001 01, then d and 5-bit address.
// RQ5 - bit-clear (prefix 0100) forces selected bit to zero, flags unchanged.
// RQ6 - bit-set (prefix 0101) forces selected bit to one, flags unchanged.
// RQ7 - bit instructions take a 5-bit file address and a 3-bit bit position.
// RQ8 - bit-test skips the next instruction when the selected bit is 0.
// RQ9 - a taken skip turns the fetched next word into a no-op: two cycles.
// RQ10 - literal-AND ANDs W with the low-byte literal into W in one cycle.
// RQ11 - both AND forms set zero flag on zero result, clear it otherwise.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module abx_exec
    import abx_pkg::*;
#(
    parameter int NUM_FILES = FILE_CNT
)(
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // instruction side
    input  wire logic                 instrValid,
    input  wire logic [INSTR_W-1:0]   instrWord,
    output logic                      discardNext,
    output logic                      instrRetired,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o
);

    logic [DATA_W-1:0] fileMem_q [NUM_FILES];
    logic [DATA_W-1:0] wReg_q;
    logic              zero_q;
    logic              skip_q;
    logic [31:0]       cycles_q;
    logic              retired_q;
    logic              ack_q;
    logic [31:0]       rdData_q;

    abx_dec_t          dec;
    abx_alu_t          alu;
    logic              execNow;
    logic [DATA_W-1:0] fOperand;

    abx_decode u_decode (
        .instr (instrWord),
        .dec   (dec)
    );

    // a word flagged by a taken skip is consumed without effect
    assign execNow  = instrValid && !skip_q;  // RQ9
    assign fOperand = fileMem_q[dec.fileAddr];

    abx_alu u_alu (
        .op      (dec.op),
        .wVal    (wReg_q),
        .fVal    (fOperand),
        .literal (dec.literal),
        .bitSel  (dec.bitSel),
        .res     (alu)
    );

    // ---------------- wishbone decode ----------------
    logic              busReq;
    logic              busWr;
    logic              fileHit;
    logic [FADDR_W-1:0] busFidx;

    assign busReq  = wb_cyc_i && wb_stb_i && !ack_q;
    // a write commits at the edge where the master samples ack, while it still holds the data
    assign busWr   = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    assign fileHit = wb_adr_i[FILE_SEL];
    assign busFidx = wb_adr_i[FIDX_LSB +: FADDR_W];

    function automatic logic isReg(input logic [WB_ADDR_W-1:0] a,
                                   input logic [WB_ADDR_W-1:0] r);
        isReg = (a[WB_ADDR_W-1:FIDX_LSB] == r[WB_ADDR_W-1:FIDX_LSB]);
    endfunction

    // ---------------- instruction effects ----------------
    logic instrWritesW;
    logic instrWritesF;
    logic instrWritesZ;

    always_comb begin
        instrWritesW = 1'b0;
        instrWritesF = 1'b0;
        instrWritesZ = 1'b0;
        if (execNow) begin
            case (dec.op)
                ABX_OP_ANDL: begin
                    instrWritesW = 1'b1;  // RQ10
                    instrWritesZ = 1'b1;  // RQ11
                end
                ABX_OP_ANDF: begin
                    instrWritesW = !dec.destFile;  // RQ2
                    instrWritesF = dec.destFile;   // RQ3
                    instrWritesZ = 1'b1;           // RQ11
                end
                ABX_OP_BCLR,
                ABX_OP_BSET: begin
                    instrWritesF = 1'b1;  // RQ5 RQ6
                end
                default: begin
                    instrWritesW = 1'b0;
                end
            endcase
        end
    end

    // file registers: an instruction write in the same cycle wins over the bus
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_FILES; i++) begin
                fileMem_q[i] <= 8'h00;
            end
        end else begin
            if (busWr && fileHit) begin
                fileMem_q[busFidx] <= wb_dat_i[DATA_W-1:0];
            end
            if (instrWritesF) begin
                fileMem_q[dec.fileAddr] <= alu.value;  // RQ3
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wReg_q <= WREG_RST;
        end else if (instrWritesW) begin
            wReg_q <= alu.value;  // RQ1
        end else if (busWr && !fileHit && isReg(wb_adr_i, ADDR_WREG)) begin
            wReg_q <= wb_dat_i[DATA_W-1:0];
        end
    end

    // zero flag moves on AND forms or a bus write to status; bit ops leave it alone
    always_ff @(posedge core_clk) begin
        if (srst) begin
            zero_q <= 1'b0;
        end else if (instrWritesZ) begin
            zero_q <= alu.zero;  // RQ11
        end else if (busWr && !fileHit && isReg(wb_adr_i, ADDR_STATUS)) begin
            zero_q <= wb_dat_i[ST_ZERO];
        end
    end

    // skip stays pending until the next valid word has been swallowed
    always_ff @(posedge core_clk) begin
        if (srst) begin
            skip_q <= 1'b0;
        end else if (instrValid && skip_q) begin
            skip_q <= 1'b0;  // RQ9
        end else if (execNow && dec.op == ABX_OP_BTSC) begin
            skip_q <= !alu.bitSet;  // RQ8
        end
    end

    assign discardNext = skip_q;  // RQ9

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cycles_q  <= CYCLES_RST;
            retired_q <= 1'b0;
        end else begin
            retired_q <= instrValid;
            if (instrValid) begin
                cycles_q <= cycles_q + 32'h0000_0001;
            end
        end
    end

    assign instrRetired = retired_q;

    // ---------------- wishbone answer ----------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdData_q <= 32'h0000_0000;
        end else if (busReq) begin
            rdData_q <= 32'h0000_0000;
            if (fileHit) begin
                rdData_q[DATA_W-1:0] <= fileMem_q[busFidx];
            end else if (isReg(wb_adr_i, ADDR_WREG)) begin
                rdData_q[DATA_W-1:0] <= wReg_q;
            end else if (isReg(wb_adr_i, ADDR_STATUS)) begin
                rdData_q[ST_ZERO] <= zero_q;
                rdData_q[ST_SKIP] <= skip_q;
            end else if (isReg(wb_adr_i, ADDR_CYCLES)) begin
                rdData_q <= cycles_q;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

endmodule

// ### rtl/abx_pkg.sv
// abx_pkg: constants and types shared by the AND / bit set-clear executor.
// assumes a 12-bit instruction word and a 32 x 8 file register space.
package abx_pkg;

    localparam int INSTR_W  = 12;
    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 5;
    localparam int BIT_W    = 3;
    localparam int FILE_CNT = 32;

    // instruction field positions
    localparam int F_LSB    = 0;
    localparam int F_MSB    = 4;
    localparam int D_POS    = 5;
    localparam int B_LSB    = 5;
    localparam int B_MSB    = 7;
    localparam int K_LSB    = 0;
    localparam int K_MSB    = 7;

    // opcode prefixes
    localparam logic [5:0] OPC_AND_REG   = 6'h05;  // 0001 01
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;   // 0100
    localparam logic [3:0] OPC_BIT_SET   = 4'h5;   // 0101
    localparam logic [3:0] OPC_BIT_TEST  = 4'h6;   // 0110
    localparam logic [3:0] OPC_AND_LIT   = 4'he;   // 1110

    // wishbone register map (byte addresses)
    localparam int          WB_ADDR_W   = 8;
    localparam logic [7:0]  ADDR_WREG   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_CYCLES = 8'h08;
    localparam logic [7:0]  ADDR_FILE   = 8'h80;
    localparam int          FILE_SEL    = 7;   // address bit that selects the file window
    localparam int          FIDX_LSB    = 2;

    // status bits
    localparam int ST_ZERO = 0;
    localparam int ST_SKIP = 1;

    localparam logic [7:0]  WREG_RST   = 8'h00;
    localparam logic [31:0] CYCLES_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ABX_OP_NONE  = 3'b000,
        ABX_OP_ANDL  = 3'b001,
        ABX_OP_ANDF  = 3'b010,
        ABX_OP_BCLR  = 3'b011,
        ABX_OP_BSET  = 3'b100,
        ABX_OP_BTSC  = 3'b101
    } abx_op_t;

    typedef struct packed {
        abx_op_t               op;
        logic                  destFile;
        logic [FADDR_W-1:0]    fileAddr;
        logic [BIT_W-1:0]      bitSel;
        logic [DATA_W-1:0]     literal;
    } abx_dec_t;

    typedef struct packed {
        logic [DATA_W-1:0]     value;
        logic                  zero;
        logic                  bitSet;
    } abx_alu_t;

endpackage
